/* common/rsa_pkg.sv */
// Purpose: constants and types of the serial access block of the clock
// Assumes: one byte store holds every register reachable over the two-wire link
// Notes:
// Function
// - Interrupt registers: three bytes with alarm, else one
// - Frequency output uses its interrupt register as data
// - Select bit: zero first register, one second
// - Interrupted transfer keeps its state, no self timeout
// - Stop condition returns the interface to idle
// - Stop ignored while device pulls data low
// - Start ignored while device pulls data low
// - Recovery clocks finish pending output and release data
// - Address byte read/write bit picks write or read mode
// - Output bytes leave most significant bit first
package rsa_pkg;
    localparam logic [3:0] DEV_CODE   = 4'h5;   // Arbitrary device code value
    localparam int         MEM_BYTES  = 20;
    localparam logic [4:0] MEM_LAST   = 5'h13;
    localparam logic [7:0] MEM_RST    = 8'h00;
    localparam logic [4:0] IDX_RST    = 5'h00;
    localparam logic [3:0] BYTE_BITS  = 4'h8;
    localparam int         BYTE_MSB   = 7;
    localparam int         BYTE_NEXT  = 6;

    localparam logic [2:0] CMD_STAT1  = 3'h0;
    localparam logic [2:0] CMD_STAT2  = 3'h1;
    localparam logic [2:0] CMD_RT1    = 3'h2;
    localparam logic [2:0] CMD_RT2    = 3'h3;
    localparam logic [2:0] CMD_FIRST_INTERRUPT_OUTPUT   = 3'h4;
    localparam logic [2:0] CMD_SECOND_INTERRUPT_OUTPUT   = 3'h5;
    localparam logic [2:0] CMD_CORR   = 3'h6;
    localparam logic [2:0] CMD_FREE   = 3'h7;

    localparam logic [4:0] BASE_STAT1 = 5'h00;
    localparam logic [4:0] BASE_STAT2 = 5'h01;
    localparam logic [4:0] BASE_RT1   = 5'h02;
    localparam logic [4:0] BASE_RT2   = 5'h09;
    localparam logic [4:0] BASE_FIRST_INTERRUPT_OUTPUT  = 5'h0c;
    localparam logic [4:0] BASE_SECOND_INTERRUPT_OUTPUT  = 5'h0f;
    localparam logic [4:0] BASE_CORR  = 5'h12;
    localparam logic [4:0] BASE_FREE  = 5'h13;

    localparam logic [2:0] LEN_ONE    = 3'h1;
    localparam logic [2:0] LEN_RT1    = 3'h7;
    localparam logic [2:0] LEN_RT2    = 3'h3;
    localparam logic [2:0] LEN_ALARM  = 3'h3;

    // Interrupt pin mode fields inside status register two
    localparam int         FIRST_INTERRUPT_OUTPUT_HI    = 7;
    localparam int         FIRST_INTERRUPT_OUTPUT_LO    = 5;
    localparam int         SECOND_INTERRUPT_OUTPUT_HI    = 3;
    localparam int         SECOND_INTERRUPT_OUTPUT_LO    = 1;
    localparam logic [2:0] MODE_ALARM = 3'h2;
    localparam logic [2:0] MODE_FREQ  = 3'h4;

    localparam logic [7:0] APB_IDX    = 8'h00;
    localparam logic [7:0] APB_DATA   = 8'h04;
    localparam logic [7:0] APB_STAT   = 8'h08;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK,
        ST_WR,
        ST_RD,
        ST_RACK,
        ST_WAIT
    } rsa_state_t;

    typedef struct packed {
        logic       alarm_en;
        logic       freq_en;
        logic [7:0] freq_sel;
    } rsa_int_cfg_t;
endpackage

/* core/rsa_serial_access.sv */
// Purpose: two-wire slave access of the clock registers, with APB side view
// Assumes: data changes at least two mclk cycles away from any clock edge
// Notes: bits are taken on the link clock, the protocol runs on mclk
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
module rsa_serial_access (
    input  wire logic                  mclk_i,     // Main clock
    input  wire logic                  rst_i,      // Synchronous reset
    input  wire logic                  scl_i,      // Serial link clock
    input  wire logic                  sda_i,      // Data line level
    output logic                       sda_o,      // Data drive value
    output logic                       sda_oe_o,   // Data pulled low
    input  wire logic                  psel_i,     // APB select
    input  wire logic                  penable_i,  // APB enable
    input  wire logic                  pwrite_i,   // APB write
    input  wire logic [7:0]            paddr_i,    // APB address
    input  wire logic [31:0]           pwdata_i,   // APB write data
    output logic [31:0]                prdata_o,   // APB read data
    output logic                       pready_o,   // APB ready
    output logic                       pslverr_o,  // APB error
    output rsa_pkg::rsa_int_cfg_t      first_interrupt_output_cfg_o, // First interrupt output setup
    output rsa_pkg::rsa_int_cfg_t      second_interrupt_output_cfg_o  // Second interrupt output setup
);
    // Link clock side: take the bit and flag each rising edge
    logic samp_r = 1'b0;
    logic tog_r  = 1'b0;
    logic samp_nxt;
    logic tog_nxt;

    always_comb begin
        samp_nxt = sda_i;
        tog_nxt  = ~tog_r;
    end

    always_ff @(posedge scl_i) begin
        samp_r <= samp_nxt;
        tog_r  <= tog_nxt;
    end

    // Main clock side
    logic [2:0]          s1_r;
    logic [2:0]          s2_r;
    logic [2:0]          d_r;
    rsa_pkg::rsa_state_t state_r;
    rsa_pkg::rsa_state_t state_nxt;
    logic [3:0]          cnt_r;
    logic [3:0]          cnt_nxt;
    logic [7:0]          shift_r;
    logic [7:0]          shift_nxt;
    logic [2:0]          cmd_r;
    logic [2:0]          cmd_nxt;
    logic                rw_r;
    logic                rw_nxt;
    logic [2:0]          ptr_r;
    logic [2:0]          ptr_nxt;
    logic                oe_r;
    logic                oe_nxt;
    logic                ackd_r;
    logic                ackd_nxt;
    logic [7:0]          mem_r [rsa_pkg::MEM_BYTES];
    logic [7:0]          mem_nxt [rsa_pkg::MEM_BYTES];
    logic [4:0]          idx_r;
    logic [4:0]          idx_nxt;
    logic [31:0]         prdata_r;
    logic [31:0]         prdata_nxt;
    rsa_pkg::rsa_int_cfg_t cfg1_r;
    rsa_pkg::rsa_int_cfg_t cfg1_nxt;
    rsa_pkg::rsa_int_cfg_t cfg2_r;
    rsa_pkg::rsa_int_cfg_t cfg2_nxt;

    logic       bit_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic [2:0] mode1;
    logic [2:0] mode2;
    logic       alarm1;
    logic       alarm2;
    logic [2:0] cur_len;
    logic [7:0] byte_next;
    logic       apb_wr;
    logic       mapped;

    // Index 2 toggle, 1 data, 0 clock
    assign bit_rise  = s2_r[2] ^ d_r[2];
    assign scl_fall  = d_r[0] & ~s2_r[0];
    assign start_det = d_r[0] & s2_r[0] & d_r[1] & ~s2_r[1];
    assign stop_det  = d_r[0] & s2_r[0] & ~d_r[1] & s2_r[1];

    assign mode1  = mem_r[rsa_pkg::BASE_STAT2][rsa_pkg::FIRST_INTERRUPT_OUTPUT_HI:rsa_pkg::FIRST_INTERRUPT_OUTPUT_LO];
    assign mode2  = mem_r[rsa_pkg::BASE_STAT2][rsa_pkg::SECOND_INTERRUPT_OUTPUT_HI:rsa_pkg::SECOND_INTERRUPT_OUTPUT_LO];
    assign alarm1 = (mode1 == rsa_pkg::MODE_ALARM);
    assign alarm2 = (mode2 == rsa_pkg::MODE_ALARM);

    function automatic logic [4:0] base_of(input logic [2:0] c);
        case (c)
            rsa_pkg::CMD_STAT1: base_of = rsa_pkg::BASE_STAT1;
            rsa_pkg::CMD_STAT2: base_of = rsa_pkg::BASE_STAT2;
            rsa_pkg::CMD_RT1:   base_of = rsa_pkg::BASE_RT1;
            rsa_pkg::CMD_RT2:   base_of = rsa_pkg::BASE_RT2;
            rsa_pkg::CMD_FIRST_INTERRUPT_OUTPUT:  base_of = rsa_pkg::BASE_FIRST_INTERRUPT_OUTPUT;
            rsa_pkg::CMD_SECOND_INTERRUPT_OUTPUT:  base_of = rsa_pkg::BASE_SECOND_INTERRUPT_OUTPUT;
            rsa_pkg::CMD_CORR:  base_of = rsa_pkg::BASE_CORR;
            default:            base_of = rsa_pkg::BASE_FREE;
        endcase
    endfunction

    function automatic logic [2:0] len_of(input logic [2:0] c, input logic a1, input logic a2);
        case (c)
            rsa_pkg::CMD_RT1:  len_of = rsa_pkg::LEN_RT1;
            rsa_pkg::CMD_RT2:  len_of = rsa_pkg::LEN_RT2;
            rsa_pkg::CMD_FIRST_INTERRUPT_OUTPUT: len_of = a1 ? rsa_pkg::LEN_ALARM : rsa_pkg::LEN_ONE;
            rsa_pkg::CMD_SECOND_INTERRUPT_OUTPUT: len_of = a2 ? rsa_pkg::LEN_ALARM : rsa_pkg::LEN_ONE;
            default:           len_of = rsa_pkg::LEN_ONE;
        endcase
    endfunction

    assign cur_len = len_of(cmd_r, alarm1, alarm2);

    // Byte the read will send at the advanced pointer, zero past the end
    always_comb begin
        byte_next = rsa_pkg::MEM_RST;
        if (ptr_nxt < cur_len) begin
            byte_next = mem_r[base_of(cmd_r) + {2'h0, ptr_nxt}];
        end
    end

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        shift_nxt = shift_r;
        cmd_nxt   = cmd_r;
        rw_nxt    = rw_r;
        ptr_nxt   = ptr_r;
        oe_nxt    = oe_r;
        ackd_nxt  = ackd_r;
        mem_nxt   = mem_r;
        case (state_r)
            rsa_pkg::ST_ADDR, rsa_pkg::ST_WR: begin
                if (bit_rise) begin
                    shift_nxt = {shift_r[rsa_pkg::BYTE_NEXT:0], samp_r};
                    cnt_nxt   = cnt_r + 4'h1;
                end
                if (scl_fall && cnt_r == rsa_pkg::BYTE_BITS) begin
                    cnt_nxt = 4'h0;
                    if (state_r == rsa_pkg::ST_WR) begin
                        if (ptr_r < cur_len) begin
                            mem_nxt[base_of(cmd_r) + {2'h0, ptr_r}] = shift_r;
                            ptr_nxt = ptr_r + 3'h1;
                        end
                        oe_nxt    = 1'b1;
                        state_nxt = rsa_pkg::ST_ACK;
                    end else if (shift_r[7:4] == rsa_pkg::DEV_CODE) begin
                        cmd_nxt   = shift_r[3:1];
                        rw_nxt    = shift_r[0];
                        ptr_nxt   = 3'h0;
                        oe_nxt    = 1'b1;
                        state_nxt = rsa_pkg::ST_ACK;
                    end else begin
                        state_nxt = rsa_pkg::ST_WAIT;
                    end
                end
            end
            rsa_pkg::ST_ACK: begin
                if (scl_fall) begin
                    cnt_nxt = 4'h0;
                    if (rw_r) begin
                        shift_nxt = byte_next;
                        oe_nxt    = ~byte_next[rsa_pkg::BYTE_MSB];
                        state_nxt = rsa_pkg::ST_RD;
                    end else begin
                        oe_nxt    = 1'b0;
                        state_nxt = rsa_pkg::ST_WR;
                    end
                end
            end
            rsa_pkg::ST_RD: begin
                if (bit_rise) begin
                    cnt_nxt = cnt_r + 4'h1;
                end
                if (scl_fall) begin
                    if (cnt_r == rsa_pkg::BYTE_BITS) begin
                        oe_nxt    = 1'b0;
                        cnt_nxt   = 4'h0;
                        state_nxt = rsa_pkg::ST_RACK;
                    end else begin
                        shift_nxt = {shift_r[rsa_pkg::BYTE_NEXT:0], 1'b0};
                        oe_nxt    = ~shift_r[rsa_pkg::BYTE_NEXT];
                    end
                end
            end
            rsa_pkg::ST_RACK: begin
                if (bit_rise) begin
                    ackd_nxt = ~samp_r;
                end
                if (scl_fall) begin
                    if (ackd_r) begin
                        if (ptr_r < cur_len) begin
                            ptr_nxt = ptr_r + 3'h1;
                        end
                        shift_nxt = byte_next;
                        oe_nxt    = ~byte_next[rsa_pkg::BYTE_MSB];
                        state_nxt = rsa_pkg::ST_RD;
                    end else begin
                        state_nxt = rsa_pkg::ST_WAIT;
                    end
                end
            end
            rsa_pkg::ST_IDLE, rsa_pkg::ST_WAIT: begin
                oe_nxt = 1'b0;
            end
            default: begin
                state_nxt = rsa_pkg::ST_IDLE;
                oe_nxt    = 1'b0;
            end
        endcase
        // Conditions only seen while the line is released
        if (!oe_r && start_det) begin
            state_nxt = rsa_pkg::ST_ADDR;
            cnt_nxt   = 4'h0;
            ackd_nxt  = 1'b0;
        end else if (!oe_r && stop_det) begin
            state_nxt = rsa_pkg::ST_IDLE;
            cnt_nxt   = 4'h0;
        end
        // No timeout: any other state is held until start or stop
        // Software access to the byte store; serial write above wins
        if (apb_wr && paddr_i == rsa_pkg::APB_DATA && idx_r <= rsa_pkg::MEM_LAST
            && !(state_r == rsa_pkg::ST_WR && scl_fall && cnt_r == rsa_pkg::BYTE_BITS)) begin
            mem_nxt[idx_r] = pwdata_i[7:0];
        end
    end

    // APB slave, zero wait states
    assign apb_wr    = psel_i & penable_i & pwrite_i;
    assign mapped    = (paddr_i == rsa_pkg::APB_IDX) || (paddr_i == rsa_pkg::APB_DATA)
                       || (paddr_i == rsa_pkg::APB_STAT);
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~mapped;

    always_comb begin
        idx_nxt    = idx_r;
        prdata_nxt = prdata_r;
        if (apb_wr && paddr_i == rsa_pkg::APB_IDX) begin
            idx_nxt = pwdata_i[4:0];
        end
        if (psel_i && !penable_i) begin
            case (paddr_i)
                rsa_pkg::APB_IDX:  prdata_nxt = {27'h0, idx_r};
                rsa_pkg::APB_DATA: prdata_nxt = (idx_r <= rsa_pkg::MEM_LAST) ? {24'h0, mem_r[idx_r]} : 32'h0;
                rsa_pkg::APB_STAT: prdata_nxt = {24'h0, cmd_r, rw_r, oe_r, state_r};
                default:           prdata_nxt = 32'h0;
            endcase
        end
    end

    // Interrupt pin modes follow status register two, frequency select its interrupt register
    always_comb begin
        cfg1_nxt.alarm_en = alarm1;
        cfg1_nxt.freq_en  = (mode1 == rsa_pkg::MODE_FREQ);
        cfg1_nxt.freq_sel = mem_r[rsa_pkg::BASE_FIRST_INTERRUPT_OUTPUT];
        cfg2_nxt.alarm_en = alarm2;
        cfg2_nxt.freq_en  = (mode2 == rsa_pkg::MODE_FREQ);
        cfg2_nxt.freq_sel = mem_r[rsa_pkg::BASE_SECOND_INTERRUPT_OUTPUT];
    end

    always_ff @(posedge mclk_i) begin
        s1_r <= {tog_r, sda_i, scl_i};
        s2_r <= s1_r;
        if (rst_i) begin
            d_r      <= 3'h3;
            state_r  <= rsa_pkg::ST_IDLE;
            cnt_r    <= 4'h0;
            shift_r  <= 8'h00;
            cmd_r    <= 3'h0;
            rw_r     <= 1'b0;
            ptr_r    <= 3'h0;
            oe_r     <= 1'b0;
            ackd_r   <= 1'b0;
            idx_r    <= rsa_pkg::IDX_RST;
            prdata_r <= 32'h0;
            cfg1_r   <= '0;
            cfg2_r   <= '0;
            for (int i = 0; i < rsa_pkg::MEM_BYTES; i++) begin
                mem_r[i] <= rsa_pkg::MEM_RST;
            end
        end else begin
            d_r      <= s2_r;
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            shift_r  <= shift_nxt;
            cmd_r    <= cmd_nxt;
            rw_r     <= rw_nxt;
            ptr_r    <= ptr_nxt;
            oe_r     <= oe_nxt;
            ackd_r   <= ackd_nxt;
            idx_r    <= idx_nxt;
            prdata_r <= prdata_nxt;
            cfg1_r   <= cfg1_nxt;
            cfg2_r   <= cfg2_nxt;
            mem_r    <= mem_nxt;
        end
    end

    assign sda_o      = 1'b0;
    assign sda_oe_o   = oe_r;
    assign prdata_o   = prdata_r;
    assign first_interrupt_output_cfg_o = cfg1_r;
    assign second_interrupt_output_cfg_o = cfg2_r;
endmodule

/* verification/rsa_serial_access_monitor.sv */
// Purpose: port assertions of the serial access block
// Assumes: link clock low phase far exceeds the data output delay
// Notes: bound to every instance of the block
`timescale 1ns/10ps
module rsa_serial_access_monitor (
    input wire logic                  mclk_i,     // Main clock
    input wire logic                  rst_i,      // Reset
    input wire logic                  scl_i,      // Link clock
    input wire logic                  sda_i,      // Data line
    input wire logic                  sda_o,      // Data drive value
    input wire logic                  sda_oe_o,   // Data pulled low
    input wire logic                  psel_i,     // APB select
    input wire logic                  penable_i,  // APB enable
    input wire logic                  pwrite_i,   // APB write
    input wire logic [7:0]            paddr_i,    // APB address
    input wire logic [31:0]           pwdata_i,   // APB write data
    input wire logic [31:0]           prdata_o,   // APB read data
    input wire logic                  pready_o,   // APB ready
    input wire logic                  pslverr_o,  // APB error
    input wire rsa_pkg::rsa_int_cfg_t first_interrupt_output_cfg_o, // First pin setup
    input wire rsa_pkg::rsa_int_cfg_t second_interrupt_output_cfg_o  // Second pin setup
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    logic mapped;
    assign mapped = paddr_i inside {rsa_pkg::APB_IDX, rsa_pkg::APB_DATA, rsa_pkg::APB_STAT};
    sequence s_acc;
        psel_i && penable_i;
    endsequence
    sequence s_held;
        sda_oe_o [*8];
    endsequence
    a_ready_high: assert property (s_acc |-> pready_o) else $error("access without ready");
    a_err_unmapped: assert property (s_acc ##0 !mapped |-> pslverr_o) else $error("unmapped not refused");
    a_err_cause: assert property (pslverr_o |-> s_acc ##0 !mapped) else $error("stray error");
    a_rd_zero: assert property (s_acc ##0 !pwrite_i && !mapped |-> prdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_reset_clear: assert property (@(posedge mclk_i) disable iff (1'b0)
        rst_i |=> !sda_oe_o && first_interrupt_output_cfg_o == '0 && second_interrupt_output_cfg_o == '0) else $error("reset not clean");
    a_open_drain: assert property (sda_o == 1'b0) else $error("data driven high");
    a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i) else $error("data moved, clock high");
    a_pull_held: assert property ($rose(sda_oe_o) |=> s_held) else $error("low pull too short");
    a_pin_excl: assert property (!(first_interrupt_output_cfg_o.alarm_en && first_interrupt_output_cfg_o.freq_en) &&
        !(second_interrupt_output_cfg_o.alarm_en && second_interrupt_output_cfg_o.freq_en)) else $error("alarm and frequency together");
endmodule
bind rsa_serial_access rsa_serial_access_monitor u_mon (
    .mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .first_interrupt_output_cfg_o(first_interrupt_output_cfg_o), .second_interrupt_output_cfg_o(second_interrupt_output_cfg_o)
);

/* verification/rsa_link_master.sv */
// Purpose: two-wire bus master model driving the link clock
// Assumes: data line has a pull-up; 80 ns clock period
// Notes: link clock stands still high between frames
`timescale 1ns/10ps
module rsa_link_master (
    output logic      scl_o,     // Link clock
    output logic      sda_low_o, // Master pulls data low
    input  wire logic sda_i      // Resolved data line
);
    logic s;
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic clk_bit(input logic b, output logic v);
        #20 sda_low_o = !b;
        #20 scl_o = 1'b1;
        #20 v = sda_i;
        #20 scl_o = 1'b0;
    endtask
    task automatic start();
        // Keep link edges off the main clock edges
        #1;
        #20 sda_low_o = 1'b0;
        #20 scl_o = 1'b1;
        #20 sda_low_o = 1'b1;
        #20 scl_o = 1'b0;
    endtask
    task automatic stop();
        #1;
        #20 sda_low_o = 1'b1;
        #20 scl_o = 1'b1;
        #20 sda_low_o = 1'b0;
        #40;
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
        clk_bit(1'b1, ack);
    endtask
    task automatic get_byte(input logic nack, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
        clk_bit(nack, s);
    endtask
    task automatic pulses(input int n);
        #1;
        repeat (n) clk_bit(1'b1, s);
    endtask
endmodule

/* verification/rsa_serial_access_bench.sv */
// Purpose: self-checking bench of the serial access block
// Assumes: master model owns the link, APB tasks own the registers
// Notes: random data from a fixed seed
`timescale 1ns/10ps
module rsa_serial_access_bench;
    logic                  mclk_i, rst_i, psel, penable, pwrite, pready, pslverr, oe, sda_o, m_low, sda, scl;
    logic                  ack, err;
    logic [7:0]            paddr, v;
    logic [31:0]           pwdata, prdata, rd;
    logic [7:0]            d [7];
    logic [2:0]            m;
    logic [4:0]            base;
    rsa_pkg::rsa_int_cfg_t cfg [2];
    int                    n_errors, num_checks, seed;
    assign sda = !(oe || m_low);
    rsa_serial_access u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(oe), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .first_interrupt_output_cfg_o(cfg[0]), .second_interrupt_output_cfg_o(cfg[1]));
    rsa_link_master u_mst (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda));
    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    function automatic logic [7:0] addr_byte(input logic [2:0] c, input logic r);
        return {rsa_pkg::DEV_CODE, c, r};
    endfunction
    function automatic logic [1:0] mode_bits(input logic [2:0] md);
        return {md == rsa_pkg::MODE_ALARM, md == rsa_pkg::MODE_FREQ};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (n_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge mclk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk_i);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk_i);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k == 20) begin
            n_errors++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic byte_wr(input logic [4:0] i, input logic [7:0] b);
        apb(1'b1, rsa_pkg::APB_IDX, {27'h0, i});
        apb(1'b1, rsa_pkg::APB_DATA, {24'h0, b});
    endtask
    task automatic chk_byte(input logic [4:0] i, input logic [7:0] b);
        apb(1'b1, rsa_pkg::APB_IDX, {27'h0, i});
        apb(1'b0, rsa_pkg::APB_DATA, 32'h0);
        check(rd, {24'h0, b});
    endtask
    task automatic stat_is(input logic [3:0] s);
        #40;
        apb(1'b0, rsa_pkg::APB_STAT, 32'h0);
        check(rd[3:0], s);
    endtask
    task automatic lwr(input logic [2:0] c, input int n);
        u_mst.start();
        u_mst.put_byte(addr_byte(c, 1'b0), ack);
        check(ack, 1'b0);
        for (int j = 0; j < n; j++) begin
            u_mst.put_byte(d[j], ack);
            check(ack, 1'b0);
        end
        u_mst.stop();
    endtask
    initial begin
        #360000;
        n_errors++;
        finish_test();
    end
    initial begin
        seed = 32'h6c6b4bf6;
        {rst_i, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        repeat (4) @(posedge mclk_i);
        rst_i <= 1'b0;
        stat_is(4'h0);
        check({cfg[0], cfg[1]}, 20'h0);
        apb(1'b0, 8'h0c, 32'h0);
        check({err, rd}, {1'b1, 32'h0});
        byte_wr(5'h1f, 8'hff);
        chk_byte(5'h1f, 8'h00);
        u_mst.start();
        u_mst.pulses(63);
        u_mst.stop();
        stat_is(4'h0);
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 3; k++) begin
                m = (k == 0) ? rsa_pkg::MODE_ALARM : (k == 1) ? rsa_pkg::MODE_FREQ : 3'h0;
                d[0] = (p == 0) ? {m, 5'h0} : {4'h0, m, 1'b0};
                lwr(rsa_pkg::CMD_STAT2, 1);
                base = (p == 0) ? rsa_pkg::BASE_FIRST_INTERRUPT_OUTPUT : rsa_pkg::BASE_SECOND_INTERRUPT_OUTPUT;
                for (int j = 0; j < 3; j++) begin
                    byte_wr(base + 5'(j), 8'h00);
                    d[j] = 8'($random(seed));
                end
                lwr({rsa_pkg::CMD_FIRST_INTERRUPT_OUTPUT[2:1], p[0]}, 3);
                check({cfg[p].alarm_en, cfg[p].freq_en}, mode_bits(m));
                if (m == rsa_pkg::MODE_FREQ) check(cfg[p].freq_sel, d[0]);
                for (int j = 0; j < 3; j++) chk_byte(base + 5'(j), (j == 0 || k == 0) ? d[j] : 8'h00);
            end
        end
        for (int j = 0; j < 7; j++) begin
            d[j] = 8'($random(seed));
        end
        lwr(rsa_pkg::CMD_RT1, 7);
        chk_byte(rsa_pkg::BASE_RT1, d[0]);
        u_mst.start();
        u_mst.put_byte(addr_byte(rsa_pkg::CMD_RT1, 1'b1), ack);
        check(ack, 1'b0);
        for (int j = 0; j < 7; j++) begin
            u_mst.get_byte(j == 6, v);
            check(v, d[j]);
        end
        stat_is(4'h6);
        u_mst.stop();
        stat_is(4'h0);
        u_mst.start();
        u_mst.put_byte({~rsa_pkg::DEV_CODE, rsa_pkg::CMD_STAT1, 1'b0}, ack);
        check(ack, 1'b1);
        u_mst.stop();
        u_mst.start();
        u_mst.put_byte(addr_byte(rsa_pkg::CMD_STAT1, 1'b1), ack);
        repeat (3) u_mst.clk_bit(1'b1, ack);
        #1000;
        stat_is(4'hc);
        u_mst.stop();
        stat_is(4'hc);
        u_mst.start();
        stat_is(4'hc);
        u_mst.pulses(63);
        check(oe, 1'b0);
        u_mst.stop();
        stat_is(4'h0);
        finish_test();
    end
endmodule
